// *** clock_startup_consts.vh ***
`ifndef CLOCK_STARTUP_CONSTS_VH
`define CLOCK_STARTUP_CONSTS_VH

// Register byte offsets
`define REG_CONFIG 8'h00
`define REG_STATUS 8'h04
`define REG_SLEEP_CTRL 8'h08

// Configuration register fields
`define CFG_SRC_LSB 0
`define CFG_SRC_MSB 3
`define CFG_SUT_LSB 4
`define CFG_SUT_MSB 5
`define CFG_AMP_BIT 6

// Delivered fuse state: internal RC 1 MHz, slowly rising power, amplifier unprogrammed
`define CFG_SRC_RESET 4'h1
`define CFG_SUT_RESET 2'h2
`define CFG_AMP_RESET 1'h1

// Sleep control fields
`define SLP_MODE_LSB 0
`define SLP_MODE_MSB 2
`define SLP_ENTER_BIT 3

// Sleep mode codes
`define SLEEP_IDLE 3'h0
`define SLEEP_ADC_NOISE 3'h1
`define SLEEP_POWER_DOWN 3'h2
`define SLEEP_POWER_SAVE 3'h3
`define SLEEP_STANDBY 3'h6

// Decoded clock source codes
`define SRC_EXT_CLOCK 3'h0
`define SRC_INT_RC 3'h1
`define SRC_EXT_RC 3'h2
`define SRC_LF_XTAL 3'h3
`define SRC_XTAL 3'h4

// Source select boundaries
`define SEL_XTAL_MIN 4'hA
`define SEL_LF_XTAL 4'h9
`define SEL_EXT_RC_MIN 4'h5
`define SEL_INT_RC_MIN 4'h1

// Reset delay choices
`define RDLY_NONE 2'h0
`define RDLY_SHORT 2'h1
`define RDLY_LONG 2'h2

// Start-up counts in source clock cycles (short ones)
`define WAKE_6_CK 17'h00006
`define WAKE_18_CK 17'h00012
`define WAKE_258_CK 17'h00102
`define WAKE_1K_CK 17'h00400

`endif

// *** clock_source_startup_control.v ***
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`include "clock_startup_consts.vh"

// Overview of operation
// - Decode four-bit source select into crystal, low-frequency crystal, RC, internal RC, external.
// - A fuse bit reading one is unprogrammed, zero is programmed.
// - Wake from power-down or power-save counts source cycles before execution resumes.
// - Start from reset adds an extra delay timed by the watchdog oscillator.
// - Reset delay is 4,096 or 65,536 watchdog cycles, or none.
// - Delivered settings are source select 0001 and start-up select 10.
// - Crystal mode: upper three select bits pick frequency range when amplifier unprogrammed.
// - Programmed amplifier option gives full swing; unprogrammed gives reduced low-power swing.
// - Crystal wake count from low select bit and start-up bits: 258, 1K or 16K.
// - Crystal reset delay: 4.1 ms, 65 ms or none per low bit and start-up bits.
// - Asynchronous timer allowed only while core runs from the internal oscillator.
// - Asynchronous timer clock domain keeps running in idle, ADC noise and power-save sleep for real-time counting.
// - Core, peripheral, async timer and converter clocks gate separately; memory clock follows core.
// - Program memory clock is enabled together with the core clock.
// - Converter clock keeps running in ADC noise reduction sleep while core and peripheral clocks halt.
// - Asynchronous interrupt and two-wire address detection work while peripheral clock halts.
// - Internal RC select 0001 to 0100 give 1, 2, 4, 8 MHz.
// - Internal RC: 6 CK wake; start-up 00/01/10 give none, 4.1 ms, 65 ms.
module clock_source_startup_control #(
	parameter [16:0] RESET_SHORT_CYCLES = 17'h01000,
	parameter [16:0] RESET_LONG_CYCLES = 17'h10000,
	parameter [16:0] WAKE_16K_CYCLES = 17'h04000,
	parameter [16:0] WAKE_32K_CYCLES = 17'h08000
) (
	// Clock, reset and enable
	input wire core_clk,
	input wire rst,
	input wire clk_en,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Oscillator and wake pins
	input wire source_clock_pin,
	input wire watchdog_oscillator_pin,
	input wire wake_event_pin,
	// Clock domain enables
	output reg core_clk_en_q,
	output reg io_clk_en_q,
	output reg flash_clk_en_q,
	output reg async_timer_clock_en_q,
	output reg adc_clk_en_q,
	// Decoded oscillator settings, detect enable and run status
	output reg [2:0] source_kind_q,
	output reg [1:0] xtal_range_q,
	output reg [1:0] rc_freq_q,
	output reg full_swing_q,
	output reg async_timer_allowed_q,
	output reg async_detect_en_q,
	output reg cpu_run_q
);

	localparam [1:0] ST_RESET_DELAY = 2'h0;
	localparam [1:0] ST_WAKE_COUNT = 2'h1;
	localparam [1:0] ST_RUN = 2'h2;
	localparam [1:0] ST_SLEEP = 2'h3;

	reg [3:0] src_sel_q;
	reg [1:0] sut_q;
	reg amp_opt_q;
	reg [2:0] sleep_mode_q;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [16:0] cnt_q;
	reg [16:0] cnt_d;
	reg [2:0] sync1_q;
	reg [2:0] sync2_q;
	reg [2:0] sync3_q;
	reg [2:0] level_q;
	reg [2:0] src_kind;
	reg [16:0] wake_target;
	reg [1:0] rdly_sel;
	reg [16:0] rdly_target;
	reg [1:0] xtal_range;
	reg [1:0] rc_freq;
	reg [31:0] rd_data;
	reg core_en_d;
	reg io_en_d;
	reg asy_en_d;
	reg adc_en_d;
	wire [2:0] agree;
	wire [2:0] rise;
	wire src_tick;
	wire wdt_tick;
	wire wake_seen;
	wire access;
	wire wr_cfg;
	wire wr_sleep;
	wire sleep_enter;
	wire [16:0] cnt_inc;

	// Second and third stages agreeing mark a settled level change
	assign agree = ~(sync2_q ^ sync3_q);
	assign rise = agree & sync2_q & ~level_q;
	assign src_tick = rise[0];
	assign wdt_tick = rise[1];
	assign wake_seen = rise[2];

	// Bus strobes; a write lands on the edge that raises ack
	assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_cfg = access & wb_we_i & wb_sel_i[0] & (wb_adr_i == `REG_CONFIG);
	assign wr_sleep = access & wb_we_i & wb_sel_i[0] & (wb_adr_i == `REG_SLEEP_CTRL);
	assign sleep_enter = wr_sleep & wb_dat_i[`SLP_ENTER_BIT];
	assign cnt_inc = cnt_q + 17'h00001;

	// Source select decode and start-up tables
	always @* begin
		src_kind = `SRC_EXT_CLOCK;
		wake_target = `WAKE_6_CK;
		rdly_sel = `RDLY_NONE;
		xtal_range = 2'h0;
		rc_freq = 2'h0;
		if (src_sel_q >= `SEL_XTAL_MIN) begin
			src_kind = `SRC_XTAL;
			// Reduced-swing range from upper bits; full swing has one wide range
			if (amp_opt_q) begin
				xtal_range = src_sel_q[2:1] - 2'h1;
			end
			case ({src_sel_q[0], sut_q})
				3'h0: begin
					wake_target = `WAKE_258_CK;
					rdly_sel = `RDLY_SHORT;
				end
				3'h1: begin
					wake_target = `WAKE_258_CK;
					rdly_sel = `RDLY_LONG;
				end
				3'h2: begin
					wake_target = `WAKE_1K_CK;
					rdly_sel = `RDLY_NONE;
				end
				3'h3: begin
					wake_target = `WAKE_1K_CK;
					rdly_sel = `RDLY_SHORT;
				end
				3'h4: begin
					wake_target = `WAKE_1K_CK;
					rdly_sel = `RDLY_LONG;
				end
				3'h5: begin
					wake_target = WAKE_16K_CYCLES;
					rdly_sel = `RDLY_NONE;
				end
				3'h6: begin
					wake_target = WAKE_16K_CYCLES;
					rdly_sel = `RDLY_SHORT;
				end
				default: begin
					wake_target = WAKE_16K_CYCLES;
					rdly_sel = `RDLY_LONG;
				end
			endcase
		end else if (src_sel_q == `SEL_LF_XTAL) begin
			src_kind = `SRC_LF_XTAL;
			wake_target = (sut_q[1]) ? WAKE_32K_CYCLES : `WAKE_1K_CK;
			rdly_sel = (sut_q == 2'h0) ? `RDLY_SHORT : `RDLY_LONG;
		end else if (src_sel_q >= `SEL_EXT_RC_MIN) begin
			src_kind = `SRC_EXT_RC;
			wake_target = (sut_q == 2'h3) ? `WAKE_6_CK : `WAKE_18_CK;
			case (sut_q)
				2'h0: rdly_sel = `RDLY_NONE;
				2'h2: rdly_sel = `RDLY_LONG;
				default: rdly_sel = `RDLY_SHORT;
			endcase
		end else if (src_sel_q >= `SEL_INT_RC_MIN) begin
			src_kind = `SRC_INT_RC;
			rc_freq = src_sel_q[1:0] - 2'h1;
			wake_target = `WAKE_6_CK;
			// Reserved setting 11 falls back to the longest delay
			case (sut_q)
				2'h0: rdly_sel = `RDLY_NONE;
				2'h1: rdly_sel = `RDLY_SHORT;
				default: rdly_sel = `RDLY_LONG;
			endcase
		end else begin
			// External clock shares the internal RC start-up table
			case (sut_q)
				2'h0: rdly_sel = `RDLY_NONE;
				2'h1: rdly_sel = `RDLY_SHORT;
				default: rdly_sel = `RDLY_LONG;
			endcase
		end
		case (rdly_sel)
			`RDLY_SHORT: rdly_target = RESET_SHORT_CYCLES;
			`RDLY_LONG: rdly_target = RESET_LONG_CYCLES;
			default: rdly_target = 17'h00000;
		endcase
	end

	// Start-up sequencer
	always @* begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			ST_RESET_DELAY: begin
				// Real-time part counts watchdog oscillator edges
				if (rdly_target == 17'h00000) begin
					state_d = ST_WAKE_COUNT;
					cnt_d = 17'h00000;
				end else if (wdt_tick) begin
					if (cnt_inc == rdly_target) begin
						state_d = ST_WAKE_COUNT;
						cnt_d = 17'h00000;
					end else begin
						cnt_d = cnt_inc;
					end
				end
			end
			ST_WAKE_COUNT: begin
				// Execution stays blocked until the source has settled
				if (src_tick) begin
					if (cnt_inc == wake_target) begin
						state_d = ST_RUN;
						cnt_d = 17'h00000;
					end else begin
						cnt_d = cnt_inc;
					end
				end
			end
			ST_RUN: begin
				if (sleep_enter) begin
					state_d = ST_SLEEP;
				end
			end
			default: begin
				// Only deep sleeps stop the oscillator and need a re-count
				if (wake_seen) begin
					cnt_d = 17'h00000;
					if (sleep_mode_q == `SLEEP_POWER_DOWN || sleep_mode_q == `SLEEP_POWER_SAVE) begin
						state_d = ST_WAKE_COUNT;
					end else begin
						state_d = ST_RUN;
					end
				end
			end
		endcase
	end

	// Per-domain gating by state and sleep mode
	always @* begin
		core_en_d = (state_q == ST_RUN);
		io_en_d = (state_q == ST_RUN);
		adc_en_d = (state_q == ST_RUN);
		asy_en_d = 1'b0;
		if (state_q == ST_SLEEP) begin
			io_en_d = (sleep_mode_q == `SLEEP_IDLE);
			adc_en_d = (sleep_mode_q == `SLEEP_IDLE) || (sleep_mode_q == `SLEEP_ADC_NOISE);
		end
		// On the internal RC source, timer keeps real time in every state except power-down and standby sleep
		if (src_kind == `SRC_INT_RC) begin
			asy_en_d = !(state_q == ST_SLEEP && (sleep_mode_q == `SLEEP_POWER_DOWN ||
				sleep_mode_q == `SLEEP_STANDBY));
		end
	end

	// Register read mux, unmapped addresses read zero
	always @* begin
		rd_data = 32'h00000000;
		if (wb_adr_i == `REG_CONFIG) begin
			rd_data[`CFG_SRC_MSB:`CFG_SRC_LSB] = src_sel_q;
			rd_data[`CFG_SUT_MSB:`CFG_SUT_LSB] = sut_q;
			rd_data[`CFG_AMP_BIT] = amp_opt_q;
		end else if (wb_adr_i == `REG_STATUS) begin
			rd_data[1:0] = state_q;
			rd_data[4:2] = src_kind;
			rd_data[6:5] = xtal_range;
			rd_data[8:7] = rdly_sel;
			rd_data[25:9] = cnt_q;
		end else if (wb_adr_i == `REG_SLEEP_CTRL) begin
			rd_data[`SLP_MODE_MSB:`SLP_MODE_LSB] = sleep_mode_q;
		end
	end

	// Pin synchronisers, three stages each
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
			sync3_q <= 3'h0;
			level_q <= 3'h0;
		end else if (clk_en) begin
			sync1_q <= {wake_event_pin, watchdog_oscillator_pin, source_clock_pin};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			level_q <= (agree & sync2_q) | (~agree & level_q);
		end
	end

	// Fuse image, sleep mode, bus answer and sequencer state
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			src_sel_q <= `CFG_SRC_RESET;
			sut_q <= `CFG_SUT_RESET;
			amp_opt_q <= `CFG_AMP_RESET;
			sleep_mode_q <= `SLEEP_IDLE;
			state_q <= ST_RESET_DELAY;
			cnt_q <= 17'h00000;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else if (clk_en) begin
			wb_ack_o <= access;
			wb_dat_o <= access ? rd_data : 32'h00000000;
			if (wr_cfg) begin
				src_sel_q <= wb_dat_i[`CFG_SRC_MSB:`CFG_SRC_LSB];
				sut_q <= wb_dat_i[`CFG_SUT_MSB:`CFG_SUT_LSB];
				amp_opt_q <= wb_dat_i[`CFG_AMP_BIT];
			end
			if (wr_sleep) begin
				sleep_mode_q <= wb_dat_i[`SLP_MODE_MSB:`SLP_MODE_LSB];
			end
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// Registered outputs
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			core_clk_en_q <= 1'b0;
			flash_clk_en_q <= 1'b0;
			io_clk_en_q <= 1'b0;
			adc_clk_en_q <= 1'b0;
			async_timer_clock_en_q <= 1'b0;
			source_kind_q <= `SRC_EXT_CLOCK;
			xtal_range_q <= 2'h0;
			rc_freq_q <= 2'h0;
			full_swing_q <= 1'b0;
			async_timer_allowed_q <= 1'b0;
			async_detect_en_q <= 1'b0;
			cpu_run_q <= 1'b0;
		end else if (clk_en) begin
			core_clk_en_q <= core_en_d;
			flash_clk_en_q <= core_en_d;
			io_clk_en_q <= io_en_d;
			adc_clk_en_q <= adc_en_d;
			async_timer_clock_en_q <= asy_en_d;
			source_kind_q <= src_kind;
			xtal_range_q <= xtal_range;
			rc_freq_q <= rc_freq;
			full_swing_q <= ~amp_opt_q;
			async_timer_allowed_q <= (src_kind == `SRC_INT_RC);
			async_detect_en_q <= ~io_en_d;
			cpu_run_q <= core_en_d;
		end
	end

endmodule // clock_source_startup_control

// *** clock_osc_model.sv ***
`timescale 1ns/1ps
module clock_osc_model (
	// Pacing clock
	input wire core_clk,
	// Oscillator pins
	output logic source_clock_pin,
	output logic watchdog_oscillator_pin
);
	// Oscillators stand low between bursts
	initial source_clock_pin = 1'b0;
	initial watchdog_oscillator_pin = 1'b0;

	// Burst of n cycles; each level lasts 4 core cycles to clear the 3-stage sync
	task pulse(input logic wd, input integer n);
		integer i;
		for (i = 0; i < n; i = i + 1) begin
			if (wd) watchdog_oscillator_pin <= 1'b1;
			else source_clock_pin <= 1'b1;
			repeat (4) @(posedge core_clk);
			watchdog_oscillator_pin <= 1'b0;
			source_clock_pin <= 1'b0;
			repeat (4) @(posedge core_clk);
		end
	endtask
endmodule // clock_osc_model

// *** clock_source_startup_control_asserts.sv ***
`timescale 1ns/1ps
module clock_source_startup_control_asserts (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Bus
	input wire clk_en,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	// Domain enables and status
	input wire core_clk_en_q,
	input wire io_clk_en_q,
	input wire flash_clk_en_q,
	input wire adc_clk_en_q,
	input wire [2:0] source_kind_q,
	input wire async_timer_allowed_q,
	input wire async_detect_en_q,
	input wire cpu_run_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	// Bus answers
	ack_next_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
		else $error("Request not acknowledged next cycle");
	ack_one_cycle_a: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
		else $error("Ack longer than a cycle");
	data_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("Read data not zero without ack");
	// Domain gating relations
	flash_with_core_a: assert property (flash_clk_en_q == core_clk_en_q)
		else $error("Flash clock differs from core clock");
	run_with_core_a: assert property (cpu_run_q == core_clk_en_q)
		else $error("Execution differs from core clock");
	core_needs_io_a: assert property (core_clk_en_q |-> io_clk_en_q)
		else $error("Core runs with peripheral clock off");
	io_needs_adc_a: assert property (io_clk_en_q |-> adc_clk_en_q)
		else $error("Converter clock off while peripheral runs");
	async_on_rc_a: assert property (async_timer_allowed_q == (source_kind_q == 3'h1))
		else $error("Async timer permission wrong");
	detect_io_off_a: assert property ($fell(io_clk_en_q) |-> ##[0:1] async_detect_en_q)
		else $error("Async detect not on after peripheral halt");
	reset_delay_hold_a: assert property ($fell(rst) |-> !core_clk_en_q [*8])
		else $error("Core released too soon after reset");

	// Main scenarios
	core_start_c: cover property ($rose(core_clk_en_q));
	sleep_entry_c: cover property ($fell(io_clk_en_q));
	adc_only_c: cover property (adc_clk_en_q && !io_clk_en_q);
endmodule // clock_source_startup_control_asserts

bind clock_source_startup_control clock_source_startup_control_asserts chk_inst (
	.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.core_clk_en_q(core_clk_en_q), .io_clk_en_q(io_clk_en_q),
	.flash_clk_en_q(flash_clk_en_q), .adc_clk_en_q(adc_clk_en_q),
	.source_kind_q(source_kind_q), .async_timer_allowed_q(async_timer_allowed_q),
	.async_detect_en_q(async_detect_en_q), .cpu_run_q(cpu_run_q));

// *** clock_source_startup_control_test.sv ***
`timescale 1ns/1ps
module clock_source_startup_control_test;
	// Bench state
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic req = 1'b0;
	logic we = 1'b0;
	logic wake = 1'b0;
	logic en = 1'b1;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] q;
	integer fails = 0;
	integer n_tests = 0;
	// Design and oscillator model outputs
	wire [31:0] rdat;
	wire ack, src_pin, wd_pin, core_en, io_en, flash_en, asy_en, adc_en, fsw, asy_ok, run, det;
	wire [2:0] kind;
	wire [1:0] rng, rcf;
	wire [4:0] ens = {core_en, flash_en, io_en, adc_en, asy_en};
	// Sleep table: mode code, enables while asleep, source cycles to wake
	localparam logic [15:0] SLP [5] = '{16'h8070, 16'h9030, 16'hA006, 16'hB016, 16'hE000};

	always #12.5 core_clk = ~core_clk;

	clock_osc_model osc (.core_clk(core_clk), .source_clock_pin(src_pin),
		.watchdog_oscillator_pin(wd_pin));
	clock_source_startup_control #(.RESET_SHORT_CYCLES(17'h00008), .RESET_LONG_CYCLES(17'h00010),
		.WAKE_16K_CYCLES(17'h00008), .WAKE_32K_CYCLES(17'h00010))
		clock_source_startup_control_inst (.core_clk(core_clk), .rst(rst), .clk_en(en),
		.wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .source_clock_pin(src_pin),
		.watchdog_oscillator_pin(wd_pin), .wake_event_pin(wake), .core_clk_en_q(core_en),
		.io_clk_en_q(io_en), .flash_clk_en_q(flash_en), .async_timer_clock_en_q(asy_en),
		.adc_clk_en_q(adc_en), .source_kind_q(kind), .xtal_range_q(rng), .rc_freq_q(rcf),
		.full_swing_q(fsw), .async_timer_allowed_q(asy_ok), .async_detect_en_q(det),
		.cpu_run_q(run));

	// Expected source kind from the select field
	function automatic [2:0] kind_of(input [3:0] s);
		kind_of = s >= 4'hA ? 3'h4 : s == 4'h9 ? 3'h3 : s >= 4'h5 ? 3'h2 : s >= 4'h1 ? 3'h1 : 3'h0;
	endfunction

	task chk(input [31:0] got, input [31:0] exp);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	// Single classic cycle, held until ack is sampled
	task bus(input [7:0] a, input w, input [31:0] d, output [31:0] r);
		req <= 1'b1;
		adr <= a;
		we <= w;
		wdat <= d;
		@(posedge core_clk);
		// Wait for the answer; only the hang guard ends a lost one
		while (ack !== 1'b1) begin
			@(posedge core_clk);
		end
		r = rdat;
		req <= 1'b0;
		@(posedge core_clk);
	endtask

	task wr(input [7:0] a, input [31:0] d);
		bus(a, 1'b1, d, q);
	endtask

	task t_defaults;
		bus(8'h00, 1'b0, 32'h0, q);
		chk(q, 32'h61);
		bus(8'h0C, 1'b0, 32'h0, q);
		chk(q, 32'h0);
		chk({kind, rcf, fsw, asy_ok}, 7'h11);
	endtask

	// Boot: exact watchdog count, then exact source count
	task t_boot;
		osc.pulse(1'b1, 15);
		osc.pulse(1'b0, 6);
		chk(ens, 5'h01);
		osc.pulse(1'b1, 1);
		osc.pulse(1'b0, 5);
		chk(ens, 5'h01);
		osc.pulse(1'b0, 1);
		repeat (3) @(posedge core_clk);
		chk({ens, run}, 6'h3F);
	endtask

	task t_sleep;
		integer i;
		for (i = 0; i < 5; i = i + 1) begin
			wr(8'h08, {28'h0, SLP[i][15:12]});
			repeat (3) @(posedge core_clk);
			chk(ens, SLP[i][11:4]);
			chk(det, !SLP[i][6]);
			wake <= 1'b1;
			repeat (4) @(posedge core_clk);
			wake <= 1'b0;
			repeat (4) @(posedge core_clk);
			if (SLP[i][3:0] != 4'h0) begin
				osc.pulse(1'b0, SLP[i][3:0] - 1);
				chk(core_en, 1'b0);
				osc.pulse(1'b0, 1);
			end
			repeat (3) @(posedge core_clk);
			chk({ens, run, det}, 7'h7E);
		end
	endtask

	task t_decode;
		integer i;
		for (i = 0; i < 16; i = i + 1) begin
			wr(8'h00, {25'h0, 1'b1, 2'h2, i[3:0]});
			chk(kind, kind_of(i[3:0]));
			chk(asy_ok, kind_of(i[3:0]) == 3'h1);
		end
		for (i = 0; i < 3; i = i + 1) begin
			wr(8'h00, 32'h4A + 2 * i);
			chk(rng, i);
		end
		wr(8'h00, 32'h0E);
		chk({rng, fsw}, 3'h1);
		wr(8'h00, 32'h44);
		chk(rcf, 2'h3);
		// Crystal delay codes run short, long, none through the table
		for (i = 0; i < 8; i = i + 1) begin
			wr(8'h00, 32'h4A + i[2] + 16 * i[1:0]);
			bus(8'h04, 1'b0, 32'h0, q);
			chk(q[8:7], (i + 1) % 3);
		end
		for (i = 0; i < 3; i = i + 1) begin
			wr(8'h00, 32'h41 + 16 * i);
			bus(8'h04, 1'b0, 32'h0, q);
			chk(q[8:7], i);
		end
	endtask

	// Crystal wake from power-down needs exactly 258 source cycles
	task t_xtal_wake;
		wr(8'h00, 32'h4A);
		wr(8'h08, 32'h0A);
		wake <= 1'b1;
		repeat (4) @(posedge core_clk);
		wake <= 1'b0;
		osc.pulse(1'b0, 257);
		chk(core_en, 1'b0);
		// Source edge while the enable is low must not count
		en <= 1'b0;
		osc.pulse(1'b0, 1);
		en <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(core_en, 1'b0);
		osc.pulse(1'b0, 1);
		repeat (3) @(posedge core_clk);
		chk(core_en, 1'b1);
	endtask

	task report_and_stop;
		$display("Comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		t_defaults;
		t_boot;
		t_sleep;
		t_decode;
		t_xtal_wake;
		report_and_stop;
	end

	// Hang guard, about four times the expected run
	initial begin
		#300000;
		fails = fails + 1;
		report_and_stop;
	end
endmodule // clock_source_startup_control_test
